// ==== design/dcs_pkg.sv ====
// Package for the chained configuration serial port.
// Assumes a 250 MHz core clock that oversamples the serial pins.
package dcs_pkg;

  // Frame geometry
  localparam int          FRAME_BITS = 24;
  localparam int          CNT_W      = 5;
  localparam int          ADDR_W     = 8;
  localparam int          DATA_W     = 16;
  localparam int          PIN_W      = 3;
  localparam logic [4:0]  CNT_LAST   = 5'h17;
  localparam logic [4:0]  CNT_ZERO   = 5'h00;
  localparam logic [4:0]  CNT_ONE    = 5'h01;

  // Command bytes
  localparam logic [7:0]  CMD_READ   = 8'hFE;

  // Bank 0 register offsets
  localparam logic [7:0]  ADDR_CTRL  = 8'h00;
  localparam logic [7:0]  ADDR_CHAIN = 8'h01;
  localparam logic [7:0]  ADDR_BANK  = 8'h03;
  localparam logic [7:0]  ADDR_INIT  = 8'h04;
  localparam logic [7:0]  ADDR_COPY  = 8'h06;

  // Control register fields
  localparam int          CTRL_RESET_BIT = 0;
  localparam int          CTRL_RDEN_BIT  = 1;
  localparam int          CTRL_MODE_BIT  = 2;

  // Chain length field
  localparam int          CHAIN_LSB  = 2;
  localparam int          CHAIN_MSB  = 6;

  // Reset values
  localparam logic [15:0] CHAIN_RESET = 16'h0000;
  localparam logic [15:0] BANK_RESET  = 16'h0002;
  localparam logic [15:0] INIT_RESET  = 16'h0000;
  localparam logic [15:0] DATA_ZERO   = 16'h0000;
  localparam logic [12:0] CTRL_PAD    = 13'h0000;

  // Bank select codes
  localparam logic [7:0]  BANK0_CODE = 8'h00;
  localparam logic [7:0]  BANK1_CODE = 8'h02;
  localparam logic [7:0]  BANK2_CODE = 8'h10;

  // Serial pins after synchronisation
  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic sdi;
  } dcs_pins_type;

  // One 24-bit word: address or command byte, then 16 data bits
  typedef struct packed {
    logic [7:0]  addr;
    logic [15:0] data;
  } dcs_word_type;

  typedef enum logic [1:0] {
    BANK_ZERO,
    BANK_ONE,
    BANK_TWO,
    BANK_NONE
  } dcs_bank_type;

endpackage

// ==== design/dcs_sync.sv ====
// Two-flop synchroniser for a group of asynchronous pins.
// Assumes the inputs are levels from outside the core clock domain.
`timescale 1ns/10ps
module dcs_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             rst,
  // Pins in, synchronised levels out
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] stable_reg;

  // First stage feeds only the second stage
  always_ff @(posedge core_clk) begin
    if (rst) begin
      meta_reg   <= '0;
      stable_reg <= '0;
    end else begin
      meta_reg   <= async_in;
      stable_reg <= meta_reg;
    end
  end

  assign sync_out = stable_reg;

endmodule

// ==== design/dcs_port.sv ====
// Chained configuration serial port with the bank 0 register set.
// Assumes cs_n, sclk and sdi come straight from pins; sclk is slow
// enough (at most core_clk / 6) to be oversampled by core_clk.
// A frame already running as reset ends is ignored until select idles.
//
// Contract
// - While selected, each bit on sdi leaves on sdo 24 serial clocks later.
// - After power-up or any reset, chained mode and default chain length.
// - On 0xFE in chained mode, frame end loads output shift register with addressed register.
// - Second read step returns address byte then 16-bit register contents.
// - Control bit 2 selects chained mode at 0, legacy mode at 1.
// - Control bit 1 enables legacy reads; ignored in chained mode.
// - Writing 1 to control bit 0 resets converter and all registers.
// - Chain length field bits 6:2 holds device count minus one.
// - 16-bit registers, 8-bit addresses, carried in 24-bit frames.
// - Bank 0 registers reachable whatever the bank select holds.
// - Bank select decodes 0, 2, 16 as banks 0, 1, 2; resets to bank 1.
`timescale 1ns/10ps
module dcs_port (
  // Clock and reset
  input  wire logic                core_clk,
  input  wire logic                rst,
  // Serial pins
  input  wire logic                cs_n,
  input  wire logic                sclk,
  input  wire logic                sdi,
  output logic                     sdo,
  // Configuration seen by the converter
  output logic                     legacy_mode,
  output logic                     read_enable,
  output logic [4:0]               chain_length,
  output dcs_pkg::dcs_bank_type    bank_active,
  output logic [15:0]              init_setting,
  output logic                     converter_reset
);

  // Synchronised pins and the previous value of the serial clock
  dcs_pkg::dcs_pins_type pins_raw;
  dcs_pkg::dcs_pins_type pins_sync;
  logic                  sclk_prev_reg;

  // Frame phase of the link
  typedef enum logic [1:0] {
    LINK_WAIT,
    LINK_IDLE,
    LINK_FRAME
  } dcs_link_type;

  dcs_link_type link_reg;
  dcs_link_type link_next;

  // Shift register top bits
  localparam int SHIFT_MSB = dcs_pkg::FRAME_BITS - 1;
  localparam int SHIFT_TOP = SHIFT_MSB - 1;

  // Serial datapath state
  logic [23:0]  shift_reg;
  logic [23:0]  shift_next;
  logic [4:0]   bit_cnt_reg;
  logic [4:0]   bit_cnt_next;
  logic         whole_reg;
  logic         whole_next;
  logic         sdo_reg;
  logic         sdo_next;

  // Bank 0 register storage
  logic         mode_reg;
  logic         rd_en_reg;
  logic [15:0]  chain_reg;
  logic [15:0]  bank_reg;
  logic [15:0]  init_reg;
  logic         conv_rst_reg;

  // Pin synchronisers
  assign pins_raw.cs_n = cs_n;
  assign pins_raw.sclk = sclk;
  assign pins_raw.sdi  = sdi;

  dcs_sync #(
    .WIDTH    (dcs_pkg::PIN_W)
  ) u_pin_sync (
    .core_clk (core_clk),
    .rst      (rst),
    .async_in (pins_raw),
    .sync_out (pins_sync)
  );

  // Edge history of the synchronised serial clock
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sclk_prev_reg <= 1'b0;                                         // Idle level of the clock
    end else begin
      sclk_prev_reg <= pins_sync.sclk;
    end
  end

  // Frame phase: waits for an idle select first, so the synchroniser's
  // reset level never looks like a select edge after reset
  always_comb begin
    link_next = link_reg;
    unique case (link_reg)
      LINK_WAIT: begin
        if (pins_sync.cs_n) begin
          link_next = LINK_IDLE;
        end
      end
      LINK_IDLE: begin
        if (!pins_sync.cs_n) begin
          link_next = LINK_FRAME;
        end
      end
      LINK_FRAME: begin
        if (pins_sync.cs_n) begin
          link_next = LINK_IDLE;
        end
      end
      default: begin
        link_next = LINK_WAIT;                                       // Unused code recovers
      end
    endcase
  end

  // Frame phase register; a soft reset falls at frame end, so it is left alone
  always_ff @(posedge core_clk) begin
    if (rst) begin
      link_reg <= LINK_WAIT;
    end else begin
      link_reg <= link_next;
    end
  end

  // Edge detection on the serial clock and select
  wire in_frame   = link_reg == LINK_FRAME;
  wire selected   = in_frame & ~pins_sync.cs_n;
  wire sclk_rise  = selected & pins_sync.sclk & ~sclk_prev_reg;
  wire sclk_fall  = selected & ~pins_sync.sclk & sclk_prev_reg;
  wire cs_fall    = (link_reg == LINK_IDLE) & ~pins_sync.cs_n;
  wire cs_rise    = in_frame & pins_sync.cs_n;

  // Word held at frame end; only whole multiples of 24 bits count
  dcs_pkg::dcs_word_type word;
  assign word = shift_reg;

  wire aligned    = whole_reg & (bit_cnt_reg == dcs_pkg::CNT_ZERO);
  wire frame_end  = cs_rise & aligned;
  wire is_read    = word.addr == dcs_pkg::CMD_READ;

  // Mode decisions: chained reads use 0xFE, legacy reads use read enable
  wire read_chain = ~mode_reg & is_read;
  wire read_leg   = mode_reg & rd_en_reg;
  wire do_read    = frame_end & (read_chain | read_leg);
  wire do_write   = frame_end & ~(read_chain | read_leg) & ~is_read;

  // Address of the read: third byte in chained mode, first in legacy
  wire [7:0] rd_addr = read_chain ? word.data[7:0] : word.addr;

  // Write decode, bank 0 always reachable
  wire hit_ctrl   = do_write & (word.addr == dcs_pkg::ADDR_CTRL);
  wire hit_chain  = do_write & (word.addr == dcs_pkg::ADDR_CHAIN);
  wire hit_bank   = do_write & (word.addr == dcs_pkg::ADDR_BANK);
  wire hit_init   = do_write & (word.addr == dcs_pkg::ADDR_INIT);
  wire soft_reset = hit_ctrl & word.data[dcs_pkg::CTRL_RESET_BIT];
  wire clear_all  = rst | soft_reset;

  // Copy of the control register for readback
  wire [15:0] ctrl_copy = {dcs_pkg::CTRL_PAD, mode_reg, rd_en_reg, 1'b0};

  // Read data selection; write-only and unmapped addresses read zero
  wire sel_chain  = rd_addr == dcs_pkg::ADDR_CHAIN;
  wire sel_bank   = rd_addr == dcs_pkg::ADDR_BANK;
  wire sel_init   = rd_addr == dcs_pkg::ADDR_INIT;
  wire sel_copy   = rd_addr == dcs_pkg::ADDR_COPY;

  wire [15:0] rd_data = sel_chain ? chain_reg :
                        sel_bank  ? bank_reg  :
                        sel_init  ? init_reg  :
                        sel_copy  ? ctrl_copy :
                                    dcs_pkg::DATA_ZERO;

  // Answer word: address byte, then register contents
  dcs_pkg::dcs_word_type answer;
  assign answer.addr = rd_addr;
  assign answer.data = rd_data;

  // Shift register: sample on rise, load answer at frame end
  always_comb begin
    shift_next = shift_reg;
    if (sclk_rise) begin
      shift_next = {shift_reg[SHIFT_TOP:0], pins_sync.sdi};
    end else if (do_read) begin
      shift_next = answer;
    end
  end

  // Bit counter modulo 24, remembers a whole word was seen
  always_comb begin
    bit_cnt_next = bit_cnt_reg;
    whole_next   = whole_reg;
    if (cs_fall) begin
      bit_cnt_next = dcs_pkg::CNT_ZERO;
      whole_next   = 1'b0;
    end else if (sclk_rise) begin
      if (bit_cnt_reg == dcs_pkg::CNT_LAST) begin
        bit_cnt_next = dcs_pkg::CNT_ZERO;
        whole_next   = 1'b1;
      end else begin
        bit_cnt_next = bit_cnt_reg + dcs_pkg::CNT_ONE;
      end
    end
  end

  // Output bit: oldest bit leaves on falling edges, first on select
  always_comb begin
    sdo_next = sdo_reg;
    if (cs_fall | sclk_fall) begin
      sdo_next = shift_reg[SHIFT_MSB];
    end
  end

  // Serial datapath registers
  always_ff @(posedge core_clk) begin
    if (clear_all) begin
      shift_reg   <= '0;
      bit_cnt_reg <= dcs_pkg::CNT_ZERO;
      whole_reg   <= 1'b0;
      sdo_reg     <= 1'b0;
    end else begin
      shift_reg   <= shift_next;
      bit_cnt_reg <= bit_cnt_next;
      whole_reg   <= whole_next;
      sdo_reg     <= sdo_next;
    end
  end

  // Control register: mode and read enable; reset bit is not stored
  always_ff @(posedge core_clk) begin
    if (clear_all) begin
      mode_reg  <= 1'b0;
      rd_en_reg <= 1'b0;
    end else if (hit_ctrl) begin
      mode_reg  <= word.data[dcs_pkg::CTRL_MODE_BIT];
      rd_en_reg <= word.data[dcs_pkg::CTRL_RDEN_BIT];
    end
  end

  // Chain length register, kept whole for readback
  always_ff @(posedge core_clk) begin
    if (clear_all) begin
      chain_reg <= dcs_pkg::CHAIN_RESET;
    end else if (hit_chain) begin
      chain_reg <= word.data;
    end
  end

  // Bank select register
  always_ff @(posedge core_clk) begin
    if (clear_all) begin
      bank_reg <= dcs_pkg::BANK_RESET;
    end else if (hit_bank) begin
      bank_reg <= word.data;
    end
  end

  // First initialisation setting
  always_ff @(posedge core_clk) begin
    if (clear_all) begin
      init_reg <= dcs_pkg::INIT_RESET;
    end else if (hit_init) begin
      init_reg <= word.data;
    end
  end

  // Converter reset pulse, one cycle per soft reset
  always_ff @(posedge core_clk) begin
    if (rst) begin
      conv_rst_reg <= 1'b0;
    end else begin
      conv_rst_reg <= soft_reset;
    end
  end

  // Bank decode of the select field
  wire [7:0]             bank_code = bank_reg[7:0];
  dcs_pkg::dcs_bank_type bank_decoded;
  dcs_pkg::dcs_bank_type bank_active_reg;
  assign bank_decoded = (bank_code == dcs_pkg::BANK0_CODE) ? dcs_pkg::BANK_ZERO :
                        (bank_code == dcs_pkg::BANK1_CODE) ? dcs_pkg::BANK_ONE  :
                        (bank_code == dcs_pkg::BANK2_CODE) ? dcs_pkg::BANK_TWO  :
                                                             dcs_pkg::BANK_NONE;

  // Bank output from a flip-flop, back to bank one on any reset
  always_ff @(posedge core_clk) begin
    if (clear_all) begin
      bank_active_reg <= dcs_pkg::BANK_ONE;
    end else begin
      bank_active_reg <= bank_decoded;
    end
  end

  assign bank_active = bank_active_reg;

  // Outputs
  assign sdo             = sdo_reg;
  assign legacy_mode     = mode_reg;
  assign read_enable     = rd_en_reg;
  assign chain_length    = chain_reg[dcs_pkg::CHAIN_MSB:dcs_pkg::CHAIN_LSB];
  assign init_setting    = init_reg;
  assign converter_reset = conv_rst_reg;

endmodule

// ==== dv/dcs_port_properties.sv ====
// Port checker for the chained configuration serial port.
// Assumes it is bound to the port block and sees only its pins.
`timescale 1ns/10ps
module dcs_port_properties (
  // Clock and reset
  input wire logic                  core_clk,
  input wire logic                  rst,
  // Serial pins
  input wire logic                  cs_n,
  input wire logic                  sclk,
  input wire logic                  sdi,
  input wire logic                  sdo,
  // Configuration outputs
  input wire logic                  legacy_mode,
  input wire logic                  read_enable,
  input wire logic [4:0]            chain_length,
  input wire dcs_pkg::dcs_bank_type bank_active,
  input wire logic [15:0]           init_setting,
  input wire logic                  converter_reset
);
  // One clock domain, one reset
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  // Reset values, soft reset, config timing and serial output timing
  a_reset_mode: assert property ($fell(rst) |-> !legacy_mode && !read_enable)
    else $error("mode bits not cleared by reset");
  a_reset_chain: assert property ($fell(rst) |-> chain_length == 5'h00)
    else $error("chain length not cleared by reset");
  a_reset_bank: assert property ($fell(rst) |-> bank_active == dcs_pkg::BANK_ONE)
    else $error("bank select not bank one after reset");
  a_soft_clear: assert property (converter_reset |-> ##[0:1] (chain_length == 5'h00 && init_setting == 16'h0000))
    else $error("soft reset left registers set");
  a_pulse_single: assert property (converter_reset |=> !converter_reset)
    else $error("converter reset longer than one cycle");
  a_cfg_idle: assert property (($changed(init_setting) || $changed(chain_length) || $changed(legacy_mode)) |-> cs_n)
    else $error("configuration changed inside a frame");
  a_sdo_hold: assert property (cs_n [*8] |=> $stable(sdo))
    else $error("serial out moved while deselected");
  a_sdo_edge: assert property ($changed(sdo) |-> !$past(sclk, 2))
    else $error("serial out moved outside clock low phase");

  // Main scenarios reached
  c_soft_reset: cover property (converter_reset);
  c_legacy: cover property ($rose(legacy_mode));
  c_read_en: cover property ($rose(read_enable));
endmodule

// ==== dv/dcs_host_model.sv ====
// Host controller model driving shared select, clock and data in.
// Assumes one device on the link; changes pins on core_clk falls.
`timescale 1ns/10ps
module dcs_host_model (
  // Clock
  input wire logic core_clk,
  // Serial link
  output logic      cs_n,
  output logic      sclk,
  output logic      sdi,
  input wire logic  sdo
);
  // Idle link: deselected, clock low
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    sdi  = 1'b0;
  end

  // One frame MSB first; sdo taken just before each rising clock
  task automatic xfer(input logic [47:0] tx, input int nbits, output logic [47:0] rx);
    rx = 48'h0;
    @(negedge core_clk) cs_n = 1'b0;
    for (int i = nbits - 1; i >= 0; i--) begin
      sdi = tx[i];
      repeat (5) @(negedge core_clk);
      rx = {rx[46:0], sdo};
      sclk = 1'b1;
      repeat (3) @(negedge core_clk);
      sclk = 1'b0;
    end
    repeat (5) @(negedge core_clk);
    cs_n = 1'b1;
    sdi  = ~sdi;
    repeat (8) @(negedge core_clk);
  endtask

  // Write one word to a single device
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [47:0] r;
    xfer({24'h0, a, d}, 24, r);
  endtask

  // Two-frame read: request, then fetch address and data
  task automatic rd(input logic [7:0] a, output logic [23:0] w);
    logic [47:0] r;
    xfer({24'h0, 8'hFE, 8'h00, a}, 24, r);
    xfer({24'h0, 24'hFFFFFF}, 24, r);
    w = r[23:0];
  endtask
endmodule

// ==== dv/dcs_port_tb_top.sv ====
// Testbench for the chained configuration serial port.
// Assumes the host model and checker files compile before this one.
`timescale 1ns/10ps
module dcs_port_tb_top;
  logic                  core_clk;
  logic                  rst;
  logic                  cs_n;
  logic                  sclk;
  logic                  sdi;
  logic                  sdo;
  logic                  legacy_mode;
  logic                  read_enable;
  logic                  converter_reset;
  logic [4:0]            chain_length;
  logic [15:0]           init_setting;
  dcs_pkg::dcs_bank_type bank_active;
  logic [47:0]           rx;
  logic [23:0]           w;
  int                    n_errors = 0;
  int                    n_tests = 0;
  int                    n_pulses = 0;
  localparam logic [7:0] BCODE [4] = '{8'h05, 8'h02, 8'h00, 8'h10};
  localparam int         BEXP [4] = '{3, 1, 0, 2};

  dcs_port uut (.core_clk(core_clk), .rst(rst), .cs_n(cs_n), .sclk(sclk), .sdi(sdi), .sdo(sdo),
    .legacy_mode(legacy_mode), .read_enable(read_enable), .chain_length(chain_length),
    .bank_active(bank_active), .init_setting(init_setting), .converter_reset(converter_reset));
  dcs_host_model host (.core_clk(core_clk), .cs_n(cs_n), .sclk(sclk), .sdi(sdi), .sdo(sdo));

  // Clock
  initial core_clk = 1'b0;
  always #2 core_clk = ~core_clk;

  // Converter reset pulses, counted where the output is settled
  always @(negedge core_clk) begin
    if (converter_reset === 1'b1) n_pulses++;
  end

  // Compare and count
  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Counts and verdict
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // Hang guard
  initial begin
    repeat (60000) @(posedge core_clk);
    n_errors++;
    give_verdict;
  end

  // Main sequence
  initial begin
    rst = 1'b1;
    repeat (16) @(negedge core_clk);
    rst = 1'b0;
    repeat (4) @(negedge core_clk);
    check("mode", {legacy_mode, read_enable}, 24'h0);
    check("chain", chain_length, 24'h0);
    check("bank", bank_active, dcs_pkg::BANK_ONE);
    host.rd(8'h03, w);
    check("read bank", w, 24'h030002);
    host.rd(8'h06, w);
    check("read copy", w, 24'h060000);
    $display("reset test done");
    for (int i = 0; i < 2; i++) begin
      host.wr(8'h01, {9'h0, (i ? 5'h1F : 5'h03), 2'b00});
      check("chain", chain_length, i ? 24'h1F : 24'h03);
      host.rd(8'h01, w);
      check("read chain", w, i ? 24'h01007C : 24'h01000C);
    end
    for (int i = 0; i < 4; i++) begin
      host.wr(8'h03, {8'h00, BCODE[i]});
      check("bank", bank_active, BEXP[i]);
    end
    $display("chain and bank test done");
    host.xfer({8'h04, 16'h000B, 8'h04, 16'h0003}, 48, rx);
    check("init", init_setting, 24'h0003);
    check("pass through", rx[23:0], 24'h04000B);
    host.xfer({24'h0, 8'h04, 16'h00FF}, 25, rx);
    check("odd frame", init_setting, 24'h0003);
    host.rd(8'h04, w);
    check("read init", w, 24'h040003);
    $display("chain shift test done");
    host.wr(8'h00, 16'h0002);
    check("rd enable", {legacy_mode, read_enable}, 24'h1);
    host.rd(8'h06, w);
    check("read copy", w, 24'h060002);
    host.wr(8'h00, 16'h0001);
    check("soft chain", chain_length, 24'h0);
    check("soft init", init_setting, 24'h0);
    check("soft bank", bank_active, dcs_pkg::BANK_ONE);
    check("soft mode", {legacy_mode, read_enable}, 24'h0);
    check("soft pulse", n_pulses[23:0], 24'h1);
    host.wr(8'h00, 16'h0004);
    check("legacy", {legacy_mode, read_enable}, 24'h2);
    host.wr(8'h00, 16'h0006);
    check("legacy rd enable", {legacy_mode, read_enable}, 24'h3);
    host.xfer({24'h0, 8'h03, 16'h0000}, 24, rx);
    host.xfer({24'h0, 24'hFFFFFF}, 24, rx);
    check("legacy read", rx[23:0], 24'h030002);
    $display("control test done");
    give_verdict;
  end
endmodule

bind dcs_port dcs_port_properties chk (.core_clk(core_clk), .rst(rst), .cs_n(cs_n), .sclk(sclk), .sdi(sdi),
  .sdo(sdo), .legacy_mode(legacy_mode), .read_enable(read_enable), .chain_length(chain_length),
  .bank_active(bank_active), .init_setting(init_setting), .converter_reset(converter_reset));
